// ### rtl/region_protection_unit.sv
`include "region_protection_unit_defs.svh"
`default_nettype none
module region_protection_unit
  import region_protection_pkg::*;
#(
  parameter bit UNIT_PRESENT = 1'b1
)
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        clkEnable,
  input  wire logic [31:0] address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  input  wire access_type  access,
  output verdict_type      verdict
);

  typedef struct packed {
    logic [2:0]  control;
    logic [7:0]  select;
    region_type [`RPU_NUM_REGIONS-1:0] region;
    logic        answered;
    logic [31:0] readData;
  } state_type;

  state_type state;
  state_type next_state;

  // region test: size 2^(size+1), base aligned to size
  function automatic logic regionHit(input region_type r, input logic [31:0] addr);
    logic [4:0]  size;
    logic [31:0] mask;
    logic [2:0]  sub;
    size = r.attr[5:1];
    mask = 32'h0000_0000;
    sub  = 3'h0;
    if (size < `RPU_SIZE_MIN)
      size = `RPU_SIZE_MIN;
    if (size == `RPU_SIZE_MAX)
      mask = 32'h0000_0000;
    else
      mask = ~((32'h0000_0002 << size) - 32'h0000_0001);
    if (size >= 5'h07)
      sub = 3'((addr >> (size - 5'h02)) & 32'h0000_0007);
    regionHit = r.attr[0] && ((addr & mask) == (r.base & mask)) && !r.attr[8 + sub];
  endfunction : regionHit

  // access permission decode by privilege and direction
  function automatic logic apAllows(input logic [2:0] ap, input logic priv, input logic wr);
    case (ap)
      `RPU_AP_PRIV_RW:     apAllows = priv;
      `RPU_AP_PRIV_RW_URO: apAllows = priv || !wr;
      `RPU_AP_FULL:        apAllows = 1'b1;
      `RPU_AP_PRIV_RO:     apAllows = priv && !wr;
      `RPU_AP_RO:          apAllows = !wr;
      `RPU_AP_RO_ALT:      apAllows = !wr;
      default:             apAllows = 1'b0;
    endcase
  endfunction : apAllows

  function automatic logic inRange(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
    inRange = (a >= lo) && (a <= hi);
  endfunction : inRange

  logic [`RPU_NUM_REGIONS-1:0] hits;
  logic [2:0]  selIdx;
  logic [31:0] capability;
  logic        unitOn;
  logic        isScs;
  logic        isVector;
  logic        defaultXn;

  assign selIdx = state.select[2:0];

  generate
    for (genvar g = 0; g < `RPU_NUM_REGIONS; g++)
    begin : cmp
      assign hits[g] = regionHit(state.region[g], access.address);
      region_enable_a: assert property (@(posedge clk) disable iff (!rst_n)
        hits[g] |-> state.region[g].attr[0])
        else $error("disabled region reported a hit");
    end
  endgenerate

  always_comb
  begin
    capability = 32'h0000_0000;
    capability[15:8] = UNIT_PRESENT ? `RPU_DATA_REGION_COUNT_COUNT : 8'h00;
    capability[0] = 1'b0;
  end

  // handler bypass only when the handler bit is clear
  assign unitOn = state.control[`RPU_CTRL_ENABLE] &&
                  !(access.faultHandler && !state.control[`RPU_CTRL_HFNMI]);
  assign isScs    = inRange(access.address, `RPU_SCS_BASE, `RPU_SCS_LIMIT);
  assign isVector = access.address <= `RPU_VTOR_LIMIT;
  assign defaultXn = access.address >= `RPU_XN_BASE;

  // decision is purely combinational so the core sees it in the same cycle
  always_comb
  begin
    logic [3:0]  win;
    logic        any;
    region_type  r;
    logic        ok;
    win = 4'h0;
    any = 1'b0;
    r   = '0;
    ok  = 1'b1;
    for (int i = 0; i < `RPU_NUM_REGIONS; i++)
      if (hits[i])
      begin
        win = 4'(i);
        any = 1'b1;
      end
    r = state.region[win[2:0]];
    if (!unitOn)
      ok = !(access.fetch && (defaultXn || isScs));
    else if (isScs || (isVector && !access.fetch))
      ok = !(access.fetch && isScs);
    else if (any)
      ok = apAllows(r.attr[26:24], access.privileged, access.write) &&
           !(access.fetch && r.attr[28]);
    else if (state.control[`RPU_CTRL_BGEN])
      ok = access.privileged && !(access.fetch && defaultXn);
    else
      ok = 1'b0;
    verdict.hit = unitOn && any;
    verdict.hitRegion = win;
    verdict.permit = !access.valid || ok;
    verdict.severeFault = access.valid && !ok;
    verdict.executeNever = isScs || (unitOn && any ? r.attr[28] : defaultXn);
    verdict.stronglyOrdered = isScs || (unitOn && any && r.attr[17:16] == 2'b00);
  end

  // bus: one wait cycle per request, answer when answered is set
  always_comb
  begin
    logic [31:0] wmask;
    logic [31:0] rd;
    logic        req;
    next_state = state;
    wmask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
    rd  = 32'h0000_0000;
    req = read || write;
    next_state.answered = req && !state.answered;
    case (address)
      `RPU_OFS_CAPABILITY: rd = capability;
      `RPU_OFS_CONTROL:    rd = {29'h0000_0000, state.control};
      `RPU_OFS_SELECT:     rd = {24'h00_0000, state.select};
      `RPU_OFS_BASE:       rd = {state.region[selIdx].base[31:5], 1'b0, state.select[3:0]};
      `RPU_OFS_ATTR:       rd = state.region[selIdx].attr;
      default:             rd = 32'h0000_0000;
    endcase
    if (read && !state.answered)
      next_state.readData = rd;
    if (write && !state.answered)
    begin
      case (address)
        `RPU_OFS_CONTROL:
          next_state.control = 3'((state.control & ~wmask[2:0]) | (writedata[2:0] & wmask[2:0]));
        `RPU_OFS_SELECT:
          if (writedata[7:0] < 8'(`RPU_NUM_REGIONS))
            next_state.select = writedata[7:0];
        `RPU_OFS_BASE:
          if (writedata[`RPU_BASE_VALID])
          begin
            next_state.select = {4'h0, writedata[3:0]};
            if (writedata[3:0] < 4'(`RPU_NUM_REGIONS))
              next_state.region[writedata[2:0]].base = {writedata[31:5], 5'h00};
          end
          else
            next_state.region[selIdx].base = {writedata[31:5], 5'h00};
        `RPU_OFS_ATTR:
          next_state.region[selIdx].attr = writedata & `RPU_ATTR_MASK;
        default:
          next_state.control = state.control;
      endcase
    end
  end

  assign waitrequest = (read || write) && !state.answered;
  assign readdata    = state.readData;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= '0;
    else if (clkEnable)
      state <= next_state;
  end

  enable_bit_gates_a: assert property (@(posedge clk) disable iff (!rst_n)
    (access.valid && !state.control[0] && !access.fetch) |-> verdict.permit)
    else $error("disabled unit faulted a data access");
  unmatched_fault_a: assert property (@(posedge clk) disable iff (!rst_n)
    (access.valid && unitOn && hits == '0 && !state.control[2] && !isScs && !isVector) |-> verdict.severeFault)
    else $error("unmatched access not faulted");
  bg_unpriv_a: assert property (@(posedge clk) disable iff (!rst_n)
    (access.valid && unitOn && hits == '0 && !access.privileged && !isScs && !isVector) |-> verdict.severeFault)
    else $error("unprivileged miss permitted");
  highest_region_a: assert property (@(posedge clk) disable iff (!rst_n)
    (unitOn && hits[7]) |-> verdict.hitRegion == 4'h7)
    else $error("lower region won over region seven");
  scs_xn_a: assert property (@(posedge clk) disable iff (!rst_n)
    isScs |-> (verdict.executeNever && verdict.stronglyOrdered))
    else $error("system space lost execute never");
  cap_value_a: assert property (@(posedge clk) disable iff (!rst_n)
    capability[23:16] == 8'h00 && capability[0] == 1'b0)
    else $error("capability fields wrong");
  ctrl_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    (read && !waitrequest && address == `RPU_OFS_CONTROL) |-> readdata[31:3] == 29'h0)
    else $error("control high bits nonzero");
  valid_select_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEnable && write && !waitrequest && address == `RPU_OFS_BASE && writedata[4])
    |=> state.select == {4'h0, $past(writedata[3:0])})
    else $error("selector not loaded by base write");
  handler_bypass_a: assert property (@(posedge clk) disable iff (!rst_n)
    (access.valid && access.faultHandler && !state.control[1] && !access.fetch) |-> verdict.permit)
    else $error("handler access checked with bit clear");

  region_count_a: assert property (@(posedge clk) disable iff (!rst_n)
    capability[15:8] == (UNIT_PRESENT ? `RPU_DATA_REGION_COUNT_COUNT : 8'h00))
    else $error("data region count wrong");

  unified_map_a: assert property (@(posedge clk) disable iff (!rst_n)
    capability[0] == 1'b0)
    else $error("capability reports split maps");

  bg_priv_a: assert property (@(posedge clk) disable iff (!rst_n)
    (access.valid && unitOn && hits == '0 && state.control[`RPU_CTRL_BGEN] && access.privileged && !access.fetch)
    |-> verdict.permit)
    else $error("privileged background access faulted");

  bg_fetch_xn_a: assert property (@(posedge clk) disable iff (!rst_n)
    (access.valid && unitOn && hits == '0 && state.control[`RPU_CTRL_BGEN] && access.fetch && defaultXn && !isScs)
    |-> verdict.severeFault)
    else $error("background fetch from never execute area permitted");

  bg_override_a: assert property (@(posedge clk) disable iff (!rst_n)
    (access.valid && unitOn && hits != '0 && state.control[`RPU_CTRL_BGEN] && !access.privileged &&
     !access.fetch && !isScs && !isVector && state.region[verdict.hitRegion[2:0]].attr[26:24] == `RPU_AP_FULL)
    |-> verdict.permit)
    else $error("background overrode an enabled region");

  unified_fetch_a: assert property (@(posedge clk) disable iff (!rst_n)
    (access.valid && unitOn && access.fetch && hits != '0 && !isScs &&
     state.region[verdict.hitRegion[2:0]].attr[28])
    |-> verdict.severeFault)
    else $error("fetch from execute never region permitted");

  fault_permit_a: assert property (@(posedge clk) disable iff (!rst_n)
    access.valid |-> (verdict.severeFault != verdict.permit))
    else $error("fault and permit disagree");

  idle_permit_a: assert property (@(posedge clk) disable iff (!rst_n)
    !access.valid |-> (verdict.permit && !verdict.severeFault))
    else $error("idle cycle raised a fault");

  bg_ignored_a: assert property (@(posedge clk) disable iff (!rst_n)
    (access.valid && !state.control[`RPU_CTRL_ENABLE] && access.fetch && !defaultXn && !isScs)
    |-> verdict.permit)
    else $error("disabled unit faulted an executable fetch");

  disabled_nohit_a: assert property (@(posedge clk) disable iff (!rst_n)
    !state.control[`RPU_CTRL_ENABLE] |-> !verdict.hit)
    else $error("disabled unit reported a region hit");

  xn_default_a: assert property (@(posedge clk) disable iff (!rst_n)
    (access.valid && !unitOn && access.fetch && defaultXn) |-> verdict.severeFault)
    else $error("default map never execute area fetched");

  scs_fetch_a: assert property (@(posedge clk) disable iff (!rst_n)
    (access.valid && access.fetch && isScs) |-> verdict.severeFault)
    else $error("fetch from system space permitted");

  scs_permit_a: assert property (@(posedge clk) disable iff (!rst_n)
    (access.valid && unitOn && isScs && !access.fetch) |-> verdict.permit)
    else $error("system space data access faulted");

  vector_permit_a: assert property (@(posedge clk) disable iff (!rst_n)
    (access.valid && unitOn && isVector && !access.fetch) |-> verdict.permit)
    else $error("vector table read faulted");

  one_winner_a: assert property (@(posedge clk) disable iff (!rst_n)
    (unitOn && hits != '0) |-> (hits[verdict.hitRegion[2:0]] && (hits >> (verdict.hitRegion + 4'h1)) == 8'h00))
    else $error("winning region is not the highest hit");

  handler_check_a: assert property (@(posedge clk) disable iff (!rst_n)
    (access.valid && access.faultHandler && state.control[`RPU_CTRL_HFNMI] && state.control[`RPU_CTRL_ENABLE] &&
     hits == '0 && !state.control[`RPU_CTRL_BGEN] && !isScs && !isVector)
    |-> verdict.severeFault)
    else $error("handler access not checked with bit set");

  enable_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    !state.control[`RPU_CTRL_ENABLE] |-> !unitOn)
    else $error("unit active with enable clear");

  ctrl_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEnable && write && waitrequest && address == `RPU_OFS_CONTROL && byteenable[0])
    |=> state.control == $past(writedata[2:0]))
    else $error("control write lost");

  select_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEnable && write && waitrequest && address == `RPU_OFS_SELECT && writedata[7:0] < 8'(`RPU_NUM_REGIONS))
    |=> state.select == $past(writedata[7:0]))
    else $error("selector write lost");

  select_range_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEnable && write && waitrequest && address == `RPU_OFS_SELECT && writedata[7:0] >= 8'(`RPU_NUM_REGIONS))
    |=> $stable(state.select))
    else $error("out of range selector accepted");

  state_reset_a: assert property (@(posedge clk)
    !rst_n |-> (state == '0))
    else $error("state not cleared in reset");

  bus_answer_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEnable && (read || write) && waitrequest) |=> (!waitrequest || !(read || write)))
    else $error("bus answer late");

  idle_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(read || write) |-> !waitrequest)
    else $error("wait raised without request");

  clock_freeze_a: assert property (@(posedge clk) disable iff (!rst_n)
    !clkEnable |=> $stable(state))
    else $error("state moved with clock enable low");

  cap_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEnable && read && waitrequest && address == `RPU_OFS_CAPABILITY) |=> readdata == capability)
    else $error("capability read wrong");

  control_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEnable && read && waitrequest && address == `RPU_OFS_CONTROL)
    |=> readdata == {29'h0000_0000, $past(state.control)})
    else $error("control read wrong");

  base_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEnable && read && waitrequest && address == `RPU_OFS_BASE)
    |=> (readdata[4] == 1'b0 && readdata[3:0] == $past(state.select[3:0])))
    else $error("base read lost selector or valid");

  attr_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEnable && read && waitrequest && address == `RPU_OFS_ATTR)
    |=> readdata == $past(state.region[selIdx].attr))
    else $error("attribute read wrong");

  attr_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEnable && write && waitrequest && address == `RPU_OFS_ATTR)
    |=> (state.region[selIdx].attr & ~`RPU_ATTR_MASK) == 32'h0000_0000)
    else $error("reserved attribute bits stored");

  unmapped_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEnable && write && waitrequest && !(address inside {`RPU_OFS_CAPABILITY, `RPU_OFS_CONTROL,
     `RPU_OFS_SELECT, `RPU_OFS_BASE, `RPU_OFS_ATTR}))
    |=> ($stable(state.control) && $stable(state.select) && $stable(state.region)))
    else $error("unmapped write changed a register");

  unmapped_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEnable && read && waitrequest && !(address inside {`RPU_OFS_CAPABILITY, `RPU_OFS_CONTROL,
     `RPU_OFS_SELECT, `RPU_OFS_BASE, `RPU_OFS_ATTR}))
    |=> readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
endmodule : region_protection_unit
`default_nettype wire

// ### rtl/region_protection_unit_defs.svh
`ifndef REGION_PROTECTION_UNIT_DEFS_SVH
`define REGION_PROTECTION_UNIT_DEFS_SVH
`define RPU_NUM_REGIONS    8
`define RPU_OFS_CAPABILITY 32'hE000_ED90
`define RPU_OFS_CONTROL    32'hE000_ED94
`define RPU_OFS_SELECT     32'hE000_ED98
`define RPU_OFS_BASE       32'hE000_ED9C
`define RPU_OFS_ATTR       32'hE000_EDA0
`define RPU_DATA_REGION_COUNT_COUNT  8'h08
`define RPU_CTRL_ENABLE    0
`define RPU_CTRL_HFNMI     1
`define RPU_CTRL_BGEN      2
`define RPU_BASE_VALID     4
`define RPU_SIZE_MIN       5'h07
`define RPU_SIZE_MAX       5'h1F
`define RPU_ATTR_MASK      32'h173F_FF3F
`define RPU_SCS_BASE       32'hE000_E000
`define RPU_SCS_LIMIT      32'hE000_EFFF
`define RPU_VTOR_LIMIT     32'h0000_00FF
`define RPU_AP_NONE        3'h0
`define RPU_AP_PRIV_RW     3'h1
`define RPU_AP_PRIV_RW_URO 3'h2
`define RPU_AP_FULL        3'h3
`define RPU_AP_PRIV_RO     3'h5
`define RPU_AP_RO          3'h6
`define RPU_AP_RO_ALT      3'h7
`define RPU_XN_BASE        32'hA000_0000
`endif

// ### rtl/region_protection_pkg.sv
`default_nettype none
package region_protection_pkg;
  typedef struct packed {
    logic        valid;
    logic [31:0] address;
    logic        fetch;
    logic        write;
    logic        privileged;
    logic        faultHandler;
  } access_type;

  typedef struct packed {
    logic        permit;
    logic        severeFault;
    logic        executeNever;
    logic        stronglyOrdered;
    logic [3:0]  hitRegion;
    logic        hit;
  } verdict_type;

  typedef struct packed {
    logic [31:0] base;
    logic [31:0] attr;
  } region_type;

  typedef struct packed {
    logic        waitReq;
    logic [31:0] readData;
    logic        readValid;
  } bus_out_type;
endpackage : region_protection_pkg
`default_nettype wire

// ### sim/core_access_model.sv
`default_nettype none
module core_access_model
  import region_protection_pkg::*;
(
  input  wire logic clk,
  output access_type access
);
  timeunit 1ns;
  timeprecision 1ps;
  initial access = '0;
  // one access per call, held until the next call
  task automatic issue(input logic [31:0] addr, input logic fetch, input logic priv, input logic hnd);
    @(posedge clk);
    access <= '{valid: 1'b1, address: addr, fetch: fetch, write: !fetch, privileged: priv, faultHandler: hnd};
  endtask : issue
  // idle address inverted so a stale value never looks like a live request
  task automatic idle;
    @(posedge clk);
    access.valid <= 1'b0;
    access.address <= ~access.address;
  endtask : idle
endmodule : core_access_model
`default_nettype wire

// ### sim/region_protection_unit_tb.sv
`include "region_protection_unit_defs.svh"
`default_nettype none
module region_protection_unit_tb
  import region_protection_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [31:0] address = '0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = '0;
  logic [31:0] readdata;
  logic [31:0] readdataAbsent;
  logic        clkEnable = 1'b1;
  logic        waitrequest;
  access_type  access;
  verdict_type verdict;
  int          badCount = 0;
  int          nTests = 0;
  always #2 clk = ~clk;
  region_protection_unit dut (.clk(clk), .rst_n(rst_n), .clkEnable(clkEnable), .address(address), .read(read),
    .write(write), .byteenable(4'hF), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .access(access), .verdict(verdict));
  region_protection_unit #(.UNIT_PRESENT(1'b0)) dutAbsent (.clk(clk), .rst_n(rst_n), .clkEnable(clkEnable),
    .address(address), .read(read), .write(write), .byteenable(4'hF), .writedata(writedata),
    .readdata(readdataAbsent), .waitrequest(), .access(access), .verdict());
  core_access_model core (.clk(clk), .access(access));
  task automatic stopTest;
    $display("checks %0d mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stopTest
  task automatic checkReg(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp)
    begin
      badCount++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : checkReg
  // request held until waitrequest is seen low at a rising edge
  task automatic busCycle(input logic rd, input logic [31:0] addr, input logic [31:0] data, output logic [31:0] got);
    int i;
    @(posedge clk);
    address <= addr;
    read <= rd;
    write <= !rd;
    writedata <= data;
    for (i = 0; i < 40; i++)
    begin
      @(posedge clk);
      if (waitrequest === 1'b0)
        break;
    end
    got = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (i == 40)
    begin
      badCount++;
      stopTest();
    end
  endtask : busCycle
  task automatic wr(input logic [31:0] addr, input logic [31:0] data);
    logic [31:0] unused;
    busCycle(1'b0, addr, data, unused);
  endtask : wr
  task automatic rdChk(input logic [31:0] addr, input logic [31:0] exp);
    logic [31:0] got;
    busCycle(1'b1, addr, 32'h0000_0000, got);
    checkReg(got, exp);
  endtask : rdChk
  // verdict is combinational, so it is judged in the cycle the access is shown
  task automatic checkVerdict(input logic [31:0] addr, input logic fetch, input logic priv, input logic hnd,
                              input logic permit);
    core.issue(addr, fetch, priv, hnd);
    @(negedge clk);
    checkReg({30'h0000_0000, verdict.permit, verdict.severeFault}, {30'h0000_0000, permit, !permit});
  endtask : checkVerdict
  task automatic resetScenario;
    rdChk(`RPU_OFS_CONTROL, 32'h0000_0000);
    rdChk(`RPU_OFS_CAPABILITY, 32'h0000_0800);
    checkReg(readdataAbsent, 32'h0000_0000);
    rdChk(32'hE000_EDA4, 32'h0000_0000);
    rdChk(`RPU_OFS_ATTR, 32'h0000_0000);
  endtask : resetScenario
  task automatic backgroundScenario;
    wr(`RPU_OFS_CONTROL, 32'h0000_0004);
    checkVerdict(32'h2000_0010, 1'b0, 1'b0, 1'b0, 1'b1);
    wr(`RPU_OFS_CONTROL, 32'hFFFF_FFFF);
    rdChk(`RPU_OFS_CONTROL, 32'h0000_0007);
    checkVerdict(32'h3000_0000, 1'b0, 1'b0, 1'b0, 1'b0);
    checkVerdict(32'h3000_0000, 1'b0, 1'b1, 1'b0, 1'b1);
  endtask : backgroundScenario
  task automatic selectScenario;
    wr(`RPU_OFS_SELECT, 32'h0000_0002);
    wr(`RPU_OFS_SELECT, 32'h0000_0009);
    rdChk(`RPU_OFS_SELECT, 32'h0000_0002);
    wr(`RPU_OFS_BASE, 32'h2000_0010);
    rdChk(`RPU_OFS_SELECT, 32'h0000_0000);
  endtask : selectScenario
  task automatic regionScenario;
    wr(`RPU_OFS_ATTR, 32'h0300_0013);
    wr(`RPU_OFS_BASE, 32'h2000_0013);
    rdChk(`RPU_OFS_SELECT, 32'h0000_0003);
    rdChk(`RPU_OFS_BASE, 32'h2000_0003);
    wr(`RPU_OFS_ATTR, 32'h0000_000F);
    wr(`RPU_OFS_CONTROL, 32'h0000_0001);
    checkVerdict(32'h2000_0010, 1'b0, 1'b0, 1'b0, 1'b0);
    checkReg({27'h000_0000, verdict.hit, verdict.hitRegion}, 32'h0000_0013);
    checkVerdict(32'h2000_0010, 1'b1, 1'b0, 1'b0, 1'b0);
    checkVerdict(32'h2000_0110, 1'b0, 1'b0, 1'b0, 1'b1);
    checkReg({27'h000_0000, verdict.hit, verdict.hitRegion}, 32'h0000_0010);
    checkVerdict(32'h2000_0400, 1'b0, 1'b1, 1'b0, 1'b0);
    checkVerdict(32'hE000_ED00, 1'b0, 1'b0, 1'b0, 1'b1);
  endtask : regionScenario
  task automatic handlerScenario;
    checkVerdict(32'h3000_0000, 1'b0, 1'b0, 1'b1, 1'b1);
    wr(`RPU_OFS_CONTROL, 32'h0000_0003);
    checkVerdict(32'h3000_0000, 1'b0, 1'b0, 1'b1, 1'b0);
  endtask : handlerScenario
  task automatic disabledScenario;
    wr(`RPU_OFS_CONTROL, 32'h0000_0000);
    checkVerdict(32'hE000_E100, 1'b0, 1'b1, 1'b0, 1'b1);
    checkReg({30'h0000_0000, verdict.executeNever, verdict.stronglyOrdered}, 32'h0000_0003);
    @(posedge clk);
    clkEnable <= 1'b0;
    @(posedge clk);
    clkEnable <= 1'b1;
    rdChk(`RPU_OFS_CONTROL, 32'h0000_0000);
  endtask : disabledScenario
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    resetScenario();
    backgroundScenario();
    selectScenario();
    regionScenario();
    handlerScenario();
    disabledScenario();
    core.idle();
    stopTest();
  end
endmodule : region_protection_unit_tb
`default_nettype wire
